/* core/psc_rcl_pkg.sv */
// Package: register map, field layout and constants for power-on status and setup recall
// Functional notes
// - A write of 1 or 0 to the power-on clear control stores that value as the power-on clear flag.
// - With the flag at 1 the power-on event bit stays 0 through the whole boot sequence.
// - With the flag at 0 the power-on event bit is set to 1 during the boot sequence.
// - With the LAN link selected the boot-time service request is never raised.
// - The flag query returns the flag as one ASCII digit followed by a newline.
// - A recall restores the complete instrument state from the named slot.
// - Slot numbers 0 to 9 are all general purpose and usable for recall.
// - Recall of a never-saved slot restores nothing and raises a display error.
// - A save copies the present instrument state into the named slot 0 to 9.
// - Bit 5 of the service enable mask lets the event summary bit request service.
package psc_rcl_pkg;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_ESE       = 8'h08;
  localparam logic [7:0]  ADDR_SRE       = 8'h0C;
  localparam logic [7:0]  ADDR_ESR       = 8'h10;
  localparam logic [7:0]  ADDR_STATE     = 8'h14;
  localparam logic [7:0]  ADDR_SLOTCMD   = 8'h18;
  localparam logic [7:0]  ADDR_PSCQUERY  = 8'h1C;
  localparam int          CTRL_PSC_BIT   = 0;
  localparam int          CTRL_LAN_BIT   = 1;
  localparam int          CTRL_ERRCLR    = 2;
  localparam int          SLOT_NUM_LSB   = 0;
  localparam int          SLOT_SAVE_BIT  = 8;
  localparam int          SLOT_RCL_BIT   = 9;
  localparam int          ESR_PON_BIT    = 7;
  localparam int          STB_ESB_BIT    = 5;
  localparam int          STB_RQS_BIT    = 6;
  localparam int          ST_BOOTED_BIT  = 0;
  localparam int          ST_SRQ_BIT     = 1;
  localparam int          ST_DISPERR_BIT = 2;
  localparam int          ST_PARERR_BIT  = 3;
  localparam int          NUM_SLOTS      = 10;
  localparam logic [3:0]  MAX_SLOT       = 4'h9;
  localparam int          STATE_W        = 32;
  localparam logic [7:0]  ASCII_ZERO     = 8'h30;
  localparam logic [7:0]  ASCII_NL       = 8'h0A;
  localparam int          BOOT_NS        = 1000;
  localparam int          CLK_NS         = 10;
  localparam int          BOOT_CYC       = (BOOT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  BOOT_CYC_W     = 8'(BOOT_CYC);
  localparam logic [31:0] STATE_RESET    = 32'h0000_0000;
  localparam logic        PSC_RESET      = 1'b1;
  typedef enum logic [1:0] {BOOTING, READY, RESTORE} phase_t;
endpackage : psc_rcl_pkg

/* core/setup_slot_mem.sv */
// Small setup store: ten slots of instrument state, registered read
`timescale 1ns/1ps
module setup_slot_mem
  import psc_rcl_pkg::*;
(
  // Clock
  input  wire logic               sys_clk,
  // Write port
  input  wire logic               wrEn,
  input  wire logic [3:0]         wrSlot,
  input  wire logic [STATE_W-1:0] wrData,
  // Read port
  input  wire logic [3:0]         rdSlot,
  output logic      [STATE_W-1:0] rdData
);
  logic [STATE_W-1:0] mem [NUM_SLOTS];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrSlot] <= wrData;
    end
    rdData <= mem[rdSlot];
  end
endmodule : setup_slot_mem

/* core/slot_valid_bits.sv */
// Per-slot written flags, one bit per save slot
`timescale 1ns/1ps
module slot_valid_bits
  import psc_rcl_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Mark a slot as written
  input  wire logic                 setEn,
  input  wire logic [3:0]           setSlot,
  // Flags
  output logic      [NUM_SLOTS-1:0] written
);
  genvar i;
  generate
    for (i = 0; i < NUM_SLOTS; i++) begin : g_slot
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          written[i] <= 1'b0;
        end else if (setEn && setSlot == 4'(i)) begin
          written[i] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule : slot_valid_bits

/* core/psc_rcl_ctrl.sv */
// Power-on status clear, event/service enables and save/recall of instrument setup
`timescale 1ns/1ps
module psc_rcl_ctrl
  import psc_rcl_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Instrument
  output logic      [STATE_W-1:0] instState,
  output logic                    srq,
  output logic                    displayErr
);
  logic               pscFlag_q;
  logic               lanSel_q;
  logic [7:0]         ese_q;
  logic [7:0]         sre_q;
  logic [7:0]         esr_q;
  logic [7:0]         bootCnt_q;
  logic               parErr_q;
  phase_t             phase_q;
  logic [STATE_W-1:0] slotData;
  logic [NUM_SLOTS-1:0] written;

  // Decode
  wire        acc      = psel && penable;
  wire        wrAcc    = acc && pwrite;
  wire        wrCtrl   = wrAcc && paddr == ADDR_CTRL;
  wire        wrEse    = wrAcc && paddr == ADDR_ESE;
  wire        wrSre    = wrAcc && paddr == ADDR_SRE;
  wire        wrEsr    = wrAcc && paddr == ADDR_ESR;
  wire        wrState  = wrAcc && paddr == ADDR_STATE;
  wire        wrSlot   = wrAcc && paddr == ADDR_SLOTCMD;
  wire [3:0]  slotArg  = pwdata[SLOT_NUM_LSB +: 4];
  wire        slotOk   = slotArg <= MAX_SLOT;
  wire        saveCmd  = wrSlot && pwdata[SLOT_SAVE_BIT] && slotOk;
  wire        rclCmd   = wrSlot && pwdata[SLOT_RCL_BIT] && !pwdata[SLOT_SAVE_BIT];
  wire        rclBad   = rclCmd && !slotOk;
  wire        rclEmpty = rclCmd && slotOk && !written[slotArg];
  wire        rclGo    = rclCmd && slotOk && written[slotArg] && phase_q == READY;
  wire        bootDone = phase_q == BOOTING && bootCnt_q == BOOT_CYC_W;
  wire        esbSum   = |(esr_q & ese_q);
  wire [7:0]  stb      = {1'b0, 1'b0, esbSum, 5'h00};
  wire        srqReq   = |(stb & sre_q);
  wire        srqOut   = srqReq && phase_q != BOOTING && !lanSel_q;
  wire        mapped   = paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_ESE ||
                         paddr == ADDR_SRE || paddr == ADDR_ESR || paddr == ADDR_STATE ||
                         paddr == ADDR_SLOTCMD || paddr == ADDR_PSCQUERY;
  wire [7:0]  pscChar  = ASCII_ZERO + {7'h00, pscFlag_q};
  wire [31:0] statusW  = {28'h0000000, parErr_q, displayErr, srqOut, phase_q != BOOTING};
  wire [31:0] rdMux    =
      paddr == ADDR_CTRL     ? {29'h0000000, 1'b0, lanSel_q, pscFlag_q} :
      paddr == ADDR_STATUS   ? statusW :
      paddr == ADDR_ESE      ? {24'h000000, ese_q} :
      paddr == ADDR_SRE      ? {24'h000000, sre_q} :
      paddr == ADDR_ESR      ? {24'h000000, esr_q} :
      paddr == ADDR_STATE    ? instState :
      paddr == ADDR_PSCQUERY ? {16'h0000, pscChar, ASCII_NL} : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  setup_slot_mem u_mem (
    .sys_clk (sys_clk),
    .wrEn    (saveCmd),
    .wrSlot  (slotArg),
    .wrData  (instState),
    .rdSlot  (slotArg),
    .rdData  (slotData)
  );

  slot_valid_bits u_valid (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .setEn   (saveCmd),
    .setSlot (slotArg),
    .written (written)
  );

  // Flag has no reset: like a stored setting it outlives a reboot, so the
  // host must load it once before the first boot decides the power-on bit
  always_ff @(posedge sys_clk) begin
    if (wrCtrl) begin
      pscFlag_q <= pwdata[CTRL_PSC_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lanSel_q <= 1'b0;
    end else if (wrCtrl) begin
      lanSel_q <= pwdata[CTRL_LAN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ese_q <= 8'h00;
      sre_q <= 8'h00;
    end else begin
      if (wrEse) ese_q <= pwdata[7:0];
      if (wrSre) sre_q <= pwdata[7:0];
    end
  end

  // Boot sets the power-on bit unless the clear flag is 1; a write of 1 clears a bit
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      esr_q <= 8'h00;
    end else if (phase_q == BOOTING) begin
      esr_q[ESR_PON_BIT] <= !pscFlag_q;
    end else if (wrEsr) begin
      esr_q <= esr_q & ~pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase_q   <= BOOTING;
      bootCnt_q <= 8'h00;
    end else begin
      unique case (phase_q)
        BOOTING: begin
          bootCnt_q <= bootCnt_q + 8'h01;
          if (bootDone) phase_q <= READY;
        end
        READY: begin
          if (rclGo) begin
            phase_q <= RESTORE;
          end
        end
        RESTORE: phase_q <= READY;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      instState <= STATE_RESET;
    end else if (phase_q == RESTORE) begin
      instState <= slotData;
    end else if (wrState) begin
      instState <= pwdata;
    end
  end

  // Error flags set win over software clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      displayErr <= 1'b0;
      parErr_q   <= 1'b0;
    end else begin
      displayErr <= rclEmpty || (displayErr && !(wrCtrl && pwdata[CTRL_ERRCLR]));
      parErr_q   <= rclBad || (parErr_q && !(wrCtrl && pwdata[CTRL_ERRCLR]));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      srq    <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      srq    <= srqOut;
      prdata <= rdMux;
    end
  end

  // Assertions
  pon_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == BOOTING && $past(phase_q == BOOTING) && pscFlag_q && $past(pscFlag_q))
      |-> !esr_q[ESR_PON_BIT]) else $error("power-on bit set while clear flag is 1");
  pon_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == BOOTING && !pscFlag_q) |=> esr_q[ESR_PON_BIT])
    else $error("power-on bit not set during boot");
  flag_store_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wrCtrl |=> pscFlag_q == $past(pwdata[CTRL_PSC_BIT])) else $error("flag not stored");
  srq_boot_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (phase_q == READY && esr_q[ESR_PON_BIT] && ese_q[ESR_PON_BIT] && sre_q[STB_ESB_BIT]
     && !lanSel_q) |=> srq) else $error("service request missing after boot");
  lan_nosrq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(lanSel_q) |-> !srq) else $error("service request on LAN link");
  query_fmt_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (acc && !pwrite && paddr == ADDR_PSCQUERY) |=>
      prdata == {16'h0000, ASCII_ZERO + {7'h00, $past(pscFlag_q)}, ASCII_NL})
    else $error("flag query format wrong");
  sequence rcl_issue_s;
    rclGo;
  endsequence
  sequence rcl_load_s;
    ##2 instState == $past(slotData);
  endsequence
  recall_load_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rcl_issue_s |-> rcl_load_s) else $error("recall did not restore state");
  empty_err_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rclEmpty |=> displayErr && phase_q != RESTORE) else $error("empty slot recall");
  bad_slot_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rclBad && !wrState) |=> parErr_q && $stable(instState)) else $error("bad slot accepted");
  save_mark_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    saveCmd |=> written[$past(slotArg)]) else $error("save did not mark slot");
endmodule : psc_rcl_ctrl

/* sim/apb_host_model.sv */
// Host controller model: APB master that issues register commands to the block
`timescale 1ns/1ps
module apb_host_model (
  // Clock
  input  wire logic        sys_clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'hFF;
    pwdata  = 32'hA5A5_A5A5;
  end

  // One transfer; read data and error are taken at the edge where pready is high
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                      output logic [31:0] rdata, output logic err);
    begin
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      // Only the bench watchdog ends a wait that never sees pready
      while (pready !== 1'b1) begin
        @(posedge sys_clk);
      end
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines carry the inverse, so a stale request never looks valid
      paddr   <= ~addr;
      pwdata  <= ~data;
      pwrite  <= ~wr;
    end
  endtask : xfer
endmodule : apb_host_model

/* sim/tb_top.sv */
// Self-checking bench for power-on status clear and setup save/recall
`timescale 1ns/1ps
module tb_top;
  import psc_rcl_pkg::*;
  logic        sys_clk, reset_n, err;
  logic        psel, penable, pwrite, pready, pslverr, srq, displayErr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, instState;
  int          nMismatch, testsRun;

  psc_rcl_ctrl psc_rcl_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instState(instState), .srq(srq),
    .displayErr(displayErr));
  apb_host_model apb_host_model_i (.sys_clk(sys_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_host_model_i.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdReg(input logic [7:0] a);
    apb_host_model_i.xfer(1'b0, a, 32'h0000_0000, rd, err);
  endtask : rdReg
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : giveVerdict

  // The flag is loaded with 1 while reset is held, so this first boot is the quiet one
  task automatic testBoot();
    rdReg(ADDR_ESR);
    check("pon during boot", 32'h0, 32'(rd[ESR_PON_BIT]));
    rdReg(ADDR_STATUS);
    check("booted early", 32'h0, 32'(rd[ST_BOOTED_BIT]));
    wr(ADDR_ESE, 32'h0000_0080);
    wr(ADDR_SRE, 32'h0000_0020);
    repeat (BOOT_CYC) @(posedge sys_clk);
    rdReg(ADDR_STATUS);
    check("booted", 32'h1, 32'(rd[ST_BOOTED_BIT]));
    rdReg(ADDR_ESR);
    check("pon after boot", 32'h0, 32'(rd[ESR_PON_BIT]));
    check("srq after quiet boot", 32'h0, 32'(srq));
  endtask : testBoot

  task automatic testFlag();
    for (int v = 0; v < 2; v++) begin
      wr(ADDR_CTRL, 32'(v));
      rdReg(ADDR_CTRL);
      check("flag", 32'(v), 32'(rd[CTRL_PSC_BIT]));
      rdReg(ADDR_PSCQUERY);
      check("flag query", {16'h0000, ASCII_ZERO + 8'(v), ASCII_NL}, rd);
    end
    wr(ADDR_CTRL, 32'h0000_0002);
    repeat (5) @(posedge sys_clk);
    check("srq on lan", 32'h0, 32'(srq));
    wr(ADDR_CTRL, 32'h0000_0001);
  endtask : testFlag

  // Flag 0 is kept through a reset, so the boot after it raises the request
  task automatic testReboot();
    wr(ADDR_CTRL, 32'h0000_0000);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdReg(ADDR_ESR);
    check("pon set in boot", 32'h1, 32'(rd[ESR_PON_BIT]));
    wr(ADDR_ESE, 32'h0000_0080);
    wr(ADDR_SRE, 32'h0000_0020);
    check("srq before ready", 32'h0, 32'(srq));
    repeat (BOOT_CYC) @(posedge sys_clk);
    check("srq after boot", 32'h1, 32'(srq));
    wr(ADDR_CTRL, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    check("srq dropped on lan", 32'h0, 32'(srq));
  endtask : testReboot

  task automatic testEmptyAndBad();
    logic [3:0] bad [3];
    bad = '{4'h4, 4'hA, 4'hF};
    wr(ADDR_STATE, 32'h1234_5678);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_SLOTCMD, 32'h0000_0200 | 32'(bad[i]));
      repeat (3) @(posedge sys_clk);
      check("state kept", 32'h1234_5678, instState);
      rdReg(ADDR_STATUS);
      if (i == 0) check("display error", 32'h1, 32'(displayErr));
      else check("param error", 32'h1, 32'(rd[ST_PARERR_BIT]));
      wr(ADDR_CTRL, 32'h0000_0005);
      @(posedge sys_clk);
      check("errors cleared", 32'h0, 32'(displayErr));
      rdReg(ADDR_STATUS);
      check("status errors cleared", 32'h0, 32'(rd[ST_PARERR_BIT:ST_DISPERR_BIT]));
    end
  endtask : testEmptyAndBad

  task automatic testSaveRecall();
    for (int s = 0; s < 10; s++) begin
      wr(ADDR_STATE, 32'hC0DE_0000 | 32'(s * 273));
      wr(ADDR_SLOTCMD, 32'h0000_0100 | 32'(s));
    end
    wr(ADDR_STATE, 32'hFFFF_0000);
    for (int s = 9; s >= 0; s--) begin
      wr(ADDR_SLOTCMD, 32'h0000_0200 | 32'(s));
      repeat (3) @(posedge sys_clk);
      check("recalled state", 32'hC0DE_0000 | 32'(s * 273), instState);
      rdReg(ADDR_STATE);
      check("state read back", 32'hC0DE_0000 | 32'(s * 273), rd);
      check("no display error", 32'h0, 32'(displayErr));
    end
  endtask : testSaveRecall

  task automatic testUnmapped();
    rdReg(8'h20);
    check("unmapped error", 32'h1, 32'(err));
    rdReg(ADDR_STATE);
    check("mapped no error", 32'h0, 32'(err));
  endtask : testUnmapped

  initial begin
    reset_n   = 1'b0;
    nMismatch = 0;
    testsRun  = 0;
    // The flag has no reset of its own, so it is loaded while reset is held
    wr(ADDR_CTRL, 32'h0000_0001);
    repeat (13) @(posedge sys_clk);
    reset_n <= 1'b1;
    testBoot();
    testFlag();
    testReboot();
    testEmptyAndBad();
    testSaveRecall();
    testUnmapped();
    giveVerdict();
  end

  // The whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    nMismatch++;
    $display("MISMATCH watchdog expected finish seen timeout");
    giveVerdict();
  end
endmodule : tb_top
